// ==== src/mcu_sup_pkg.sv ====
// Constants shared by the microcontroller support logic.
// Assumes a single master clock domain and byte-wide special registers.
package mcu_sup_pkg;
  // ==========================================================
  // Special register addresses
  localparam logic [15:0] SFR_SLEEP_CTRL  = 16'h1040;
  localparam logic [15:0] SFR_WDOG_FRAMES = 16'h1041;
  localparam logic [15:0] SFR_WAKE_LINE   = 16'h1042;
  localparam logic [15:0] SFR_WAKE_SEL    = 16'h1044;
  localparam logic [15:0] SFR_RESTART     = 16'h1045;
  localparam logic [15:0] SFR_TIMER       = 16'h1048;
  localparam logic [15:0] SFR_TABLE_BASE  = 16'h1050;
  localparam logic [15:0] SFR_RD_PAGE     = 16'h1060;
  localparam logic [15:0] SFR_RD_ADDR     = 16'h1061;
  localparam logic [15:0] SFR_WR_PAGE     = 16'h1062;
  localparam logic [15:0] SFR_WR_ADDR     = 16'h1063;
  localparam logic [15:0] SFR_RING_DATA   = 16'h1064;
  localparam logic [15:0] SFR_RING_BUSY   = 16'h1066;
  // ==========================================================
  // Field positions and codes
  localparam int          SLEEP_BIT       = 0;
  localparam int          SRAM_BYTES      = 2048;
  localparam logic [1:0]  RESTART_COLD    = 2'h0;
  localparam logic [1:0]  RESTART_WDOG    = 2'h1;
  localparam logic [7:0]  WDOG_RESET_VAL  = 8'h00;
  localparam logic [15:0] BASE_RESET_VAL  = 16'h0000;
  // Wake source selections.
  localparam logic [2:0]  WAKE_LINE       = 3'h0;
  localparam logic [2:0]  WAKE_PIPE_FE    = 3'h1;
  localparam logic [2:0]  WAKE_SENS_FE    = 3'h2;
  localparam logic [2:0]  WAKE_JPEG_FE    = 3'h3;
  localparam logic [2:0]  WAKE_FIFO_FE    = 3'h4;
endpackage

// ==== src/ring_if.sv ====
// Ring bus request and answer bundle between the window and its master.
// Assumes one clock; a request is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface ring_if;
  logic       start;
  logic       write;
  logic [7:0] page;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       busy;
  modport win (output start, write, page, addr, wdata,
               input rdata, busy);
  modport mst (input start, write, page, addr, wdata,
               output rdata, busy);
endinterface
`default_nettype wire

// ==== src/ring_master.sv ====
// Ring bus master that drives one transaction at a time onto the pins.
// Assumes the ring slave answers with a done pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ring_master (
  input  wire logic SYS_CLK,
  input  wire logic NRST,
  ring_if.mst       rif,
  output logic      req_q,
  output logic      wr_q,
  output logic [15:0] adr_q,
  output logic [7:0]  wd_q,
  input  wire logic   done,
  input  wire logic [7:0] rd
);
  // ==========================================================
  // Request held until the ring slave acknowledges.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      req_q <= 1'b0;
      wr_q  <= 1'b0;
      adr_q <= 16'h0000;
      wd_q  <= 8'h00;
    end else if (rif.start && !req_q) begin
      req_q <= 1'b1;
      wr_q  <= rif.write;
      adr_q <= {rif.page, rif.addr};
      wd_q  <= rif.wdata;
    end else if (done) begin
      req_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rif.rdata <= 8'h00;
    end else if (done && req_q && !wr_q) begin
      rif.rdata <= rd;
    end
  end

  assign rif.busy = req_q;
endmodule
`default_nettype wire

// ==== src/sram_dma.sv ====
// Two kilobyte SRAM with a host access engine and an MCU port.
// Assumes host strobes are single-cycle pulses on the master clock.
`timescale 1ns/1ps
`default_nettype none
module sram_dma #(
  parameter int DEPTH = 2048
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        h_rd,
  input  wire logic        h_wr,
  input  wire logic        logical,
  input  wire logic [15:0] h_addr,
  input  wire logic [7:0]  h_wdata,
  input  wire logic [15:0] table_base,
  output logic [7:0]       h_rdata,
  output logic             active,
  input  wire logic        m_wr,
  input  wire logic [15:0] m_addr,
  input  wire logic [7:0]  m_wdata,
  output logic [7:0]       m_rdata
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0]    mem [DEPTH];
  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_PLO  = 4'b0010,
    E_PHI  = 4'b0100,
    E_ACC  = 4'b1000
  } eng_t;
  eng_t          st_q;
  logic          wr_q;
  logic [7:0]    ptr_lo_q;
  logic [7:0]    off_q;
  logic [7:0]    wd_q;
  logic [AW-1:0] a_q;
  // ==========================================================
  // Logical accesses walk idle, pointer low, pointer high, then access; physical ones go from idle straight to access.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= E_IDLE;
      wr_q <= 1'b0;
      a_q  <= '0;
      off_q <= 8'h00;
      wd_q <= 8'h00;
      ptr_lo_q <= 8'h00;
    end else begin
      case (st_q)
        E_IDLE: if (h_rd || h_wr) begin
          wr_q <= h_wr;
          wd_q <= h_wdata;
          off_q <= h_addr[7:0];
          if (logical) begin
            a_q  <= AW'(table_base + {7'h00, h_addr[15:8], 1'b0});
            st_q <= E_PLO;
          end else begin
            a_q  <= h_addr[AW-1:0];
            st_q <= E_ACC;
          end
        end
        E_PLO: begin
          ptr_lo_q <= mem[a_q];
          a_q <= a_q + AW'(1);
          st_q <= E_PHI;
        end
        E_PHI: begin
          a_q <= AW'({mem[a_q], ptr_lo_q} + {8'h00, off_q});
          st_q <= E_ACC;
        end
        default: st_q <= E_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (st_q == E_ACC && wr_q) begin
      mem[a_q] <= wd_q;
    end else if (m_wr) begin
      mem[m_addr[AW-1:0]] <= m_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      h_rdata <= 8'h00;
    end else if (st_q == E_ACC && !wr_q) begin
      h_rdata <= mem[a_q];
    end
  end

  assign m_rdata = mem[m_addr[AW-1:0]];
  assign active  = (st_q != E_IDLE);
endmodule
`default_nettype wire

// ==== src/mcu_support.sv ====
// Microcontroller support logic: SRAM access engine, sleep and wake,
// frame watchdog, profiling timer and ring bus window.
// Assumes MCU SFR strobes and pipeline events on SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module mcu_support
  import mcu_sup_pkg::*;
#(
  parameter int SRAM_DEPTH = SRAM_BYTES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        NRST,
  input  wire logic        STANDBY,
  input  wire logic        SFR_RD,
  input  wire logic        SFR_WR,
  input  wire logic [15:0] SFR_ADDR,
  input  wire logic [7:0]  SFR_WDATA,
  output logic [7:0]       SFR_RDATA,
  input  wire logic        HOST_RD,
  input  wire logic        HOST_WR,
  input  wire logic        HOST_LOGICAL,
  input  wire logic [15:0] HOST_VAR_ADDR,
  input  wire logic [7:0]  HOST_VAR_WDATA,
  output logic [7:0]       HOST_VAR_RDATA,
  input  wire logic        HOST_START_WR,
  input  wire logic [7:0]  HOST_START_CODE,
  output logic [7:0]       STARTUP_CODE,
  input  wire logic        PIPE_LINE,
  input  wire logic [15:0] PIPE_LINE_NUM,
  input  wire logic        PIPE_FRAME,
  input  wire logic        SENS_FRAME,
  input  wire logic        JPEG_FRAME,
  input  wire logic        FIFO_FRAME,
  input  wire logic        PORT_NOTIFY,
  output logic             MCU_CLK_EN,
  output logic             MCU_RST_N,
  output logic             RING_REQ,
  output logic             RING_WRITE,
  output logic [15:0]      RING_ADDR,
  output logic [7:0]       RING_WDATA,
  input  wire logic        RING_DONE,
  input  wire logic [7:0]  RING_RDATA
);
  typedef enum logic [1:0] {
    AWAKE  = 2'b01,
    ASLEEP = 2'b10
  } sleep_t;

  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] r);
    hit = (a == r);
  endfunction

  ring_if      rif ();
  sleep_t      sl_q;
  logic [7:0]  ctrl_q;
  logic [7:0]  wdog_n_q;
  logic [7:0]  frames_q;
  logic [15:0] wake_line_q;
  logic [2:0]  wake_sel_q;
  logic        wake_lvl_q;
  logic [1:0]  restart_q;
  logic [31:0] timer_q;
  logic [15:0] base_q;
  logic [7:0]  rpage_q;
  logic [7:0]  raddr_q;
  logic [7:0]  wpage_q;
  logic [7:0]  waddr_q;
  logic [1:0]  src_prev_q;
  logic        wd_fire;
  logic        dma_busy;
  logic        src;
  logic        wake;
  logic        line_hit;
  logic        sleep_ok;
  logic [7:0]  dma_rdata;
  logic [7:0]  mem_rdata;
  logic        mem_sel;
  logic        ring_req_d;
  logic        ring_wr_d;
  logic [15:0] ring_adr_d;
  logic [7:0]  ring_wd_d;
  logic [7:0]  start_q;

  // ==========================================================
  // Synchronisers for pins from the image pipeline domain.
  logic [5:0] ev_s1_q;
  logic [5:0] ev_s2_q;
  logic [5:0] ev_in;
  assign ev_in = {PORT_NOTIFY, FIFO_FRAME, JPEG_FRAME, SENS_FRAME,
                  PIPE_FRAME, PIPE_LINE};
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ev_s1_q <= 6'h00;
      ev_s2_q <= 6'h00;
    end else begin
      ev_s1_q <= ev_in;
      ev_s2_q <= ev_s1_q;
    end
  end
  logic [15:0] ln_s1_q;
  logic [15:0] ln_s2_q;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ln_s1_q <= 16'h0000;
      ln_s2_q <= 16'h0000;
    end else begin
      ln_s1_q <= PIPE_LINE_NUM;
      ln_s2_q <= ln_s1_q;
    end
  end

  // ==========================================================
  // SRAM and host variable engine.
  // two kilobyte SRAM
  sram_dma #(
    .DEPTH (SRAM_DEPTH)
  ) u_sram (
    .clk        (SYS_CLK),
    .rst_n      (NRST),
    .h_rd       (HOST_RD),
    .h_wr       (HOST_WR),
    .logical    (HOST_LOGICAL),
    .h_addr     (HOST_VAR_ADDR),
    .h_wdata    (HOST_VAR_WDATA),
    .table_base (base_q),
    .h_rdata    (dma_rdata),
    .active     (dma_busy),
    .m_wr       (SFR_WR && mem_sel),
    .m_addr     (SFR_ADDR),
    .m_wdata    (SFR_WDATA),
    .m_rdata    (mem_rdata)
  );
  assign mem_sel = (SFR_ADDR < 16'(SRAM_DEPTH));
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      HOST_VAR_RDATA <= 8'h00;
    end else begin
      HOST_VAR_RDATA <= dma_rdata;
    end
  end

  // ==========================================================
  // Wake source selection and edge or level sensitivity.
  logic [4:0] srcs;
  assign srcs = ev_s2_q[4:0];
  always_comb begin
    case (wake_sel_q)
      WAKE_PIPE_FE: src = srcs[1];
      WAKE_SENS_FE: src = srcs[2];
      WAKE_JPEG_FE: src = srcs[3];
      WAKE_FIFO_FE: src = srcs[4];
      default:      src = srcs[0];
    endcase
  end
  assign line_hit = (ln_s2_q == wake_line_q);
  assign wake = (wake_sel_q == WAKE_LINE) ? (src && line_hit && !src_prev_q[0])
              : (wake_lvl_q ? src : (src && !src_prev_q[0]));
  assign sleep_ok = !dma_busy && !line_hit && !ev_s2_q[5];

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      src_prev_q <= 2'h0;
    end else begin
      // Bit 1 keeps the last frame start seen by the watchdog.
      src_prev_q <= {ev_s2_q[1], src};
    end
  end

  // ==========================================================
  // Sleep state and control register bit 0.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !MCU_RST_N) begin
      sl_q   <= AWAKE;
      ctrl_q <= 8'h00;
    end else begin
      case (sl_q)
        AWAKE: begin
          if (SFR_RD && hit(SFR_ADDR, SFR_SLEEP_CTRL) && sleep_ok) begin
            sl_q <= ASLEEP;
          end else if (SFR_WR && hit(SFR_ADDR, SFR_SLEEP_CTRL)) begin
            ctrl_q <= SFR_WDATA;
          end
        end
        ASLEEP: begin
          if (wake) begin
            sl_q <= AWAKE;
            ctrl_q[SLEEP_BIT] <= 1'b1;
          end
        end
        default: sl_q <= AWAKE;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      MCU_CLK_EN <= 1'b1;
    end else begin
      MCU_CLK_EN <= (sl_q == AWAKE) && !(SFR_RD && sleep_ok
                    && hit(SFR_ADDR, SFR_SLEEP_CTRL));
    end
  end

  // ==========================================================
  // Frame watchdog.
  logic sleep_clr;
  assign sleep_clr = SFR_WR && hit(SFR_ADDR, SFR_SLEEP_CTRL)
                     && !SFR_WDATA[SLEEP_BIT];
  assign wd_fire = MCU_RST_N && (wdog_n_q != 8'h00)
                   && (frames_q >= wdog_n_q);
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !MCU_RST_N) begin
      frames_q <= 8'h00;
    end else if (sleep_clr) begin
      frames_q <= 8'h00;
    end else if (ev_s2_q[1] && !src_prev_q[1] && frames_q != 8'hff) begin
      frames_q <= frames_q + 8'h01;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      MCU_RST_N <= 1'b1;
    end else begin
      MCU_RST_N <= !wd_fire;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      restart_q <= RESTART_COLD;
    end else if (wd_fire) begin
      restart_q <= RESTART_WDOG;
    end else if (SFR_WR && hit(SFR_ADDR, SFR_RESTART)) begin
      restart_q <= SFR_WDATA[1:0];
    end
  end

  // ==========================================================
  // Profiling timer.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      timer_q <= 32'h00000000;
    end else if (!STANDBY) begin
      timer_q <= timer_q + 32'h00000001;
    end
  end

  // ==========================================================
  // Configuration special registers.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      wdog_n_q    <= WDOG_RESET_VAL;
      wake_line_q <= 16'h0000;
      wake_sel_q  <= WAKE_LINE;
      wake_lvl_q  <= 1'b0;
      base_q      <= BASE_RESET_VAL;
      rpage_q     <= 8'h00;
      raddr_q     <= 8'h00;
      wpage_q     <= 8'h00;
      waddr_q     <= 8'h00;
    end else if (SFR_WR) begin
      case (SFR_ADDR)
        SFR_WDOG_FRAMES:     wdog_n_q <= SFR_WDATA;
        SFR_WAKE_LINE:       wake_line_q[15:8] <= SFR_WDATA;
        SFR_WAKE_LINE + 16'h1: wake_line_q[7:0] <= SFR_WDATA;
        SFR_WAKE_SEL: begin
          wake_sel_q <= SFR_WDATA[2:0];
          wake_lvl_q <= SFR_WDATA[7];
        end
        SFR_TABLE_BASE:      base_q[15:8] <= SFR_WDATA;
        SFR_TABLE_BASE + 16'h1: base_q[7:0] <= SFR_WDATA;
        SFR_RD_PAGE:         rpage_q <= SFR_WDATA;
        SFR_RD_ADDR:         raddr_q <= SFR_WDATA;
        SFR_WR_PAGE:         wpage_q <= SFR_WDATA;
        SFR_WR_ADDR:         waddr_q <= SFR_WDATA;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Startup code register, shared by host and firmware.
  // report and mode select
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      start_q <= 8'h00;
    end else if (HOST_START_WR) begin
      start_q <= HOST_START_CODE;
    end else if (SFR_WR && hit(SFR_ADDR, SFR_RESTART + 16'h1)) begin
      start_q <= SFR_WDATA;
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      STARTUP_CODE <= 8'h00;
    end else begin
      STARTUP_CODE <= start_q;
    end
  end

  // ==========================================================
  // Ring bus window.
  // read on address write
  assign rif.start = SFR_WR && !rif.busy
                     && (hit(SFR_ADDR, SFR_RD_ADDR)
                         || hit(SFR_ADDR, SFR_RING_DATA));
  assign rif.write = hit(SFR_ADDR, SFR_RING_DATA);
  assign rif.page  = rif.write ? wpage_q : rpage_q;
  assign rif.addr  = rif.write ? waddr_q : SFR_WDATA;
  assign rif.wdata = SFR_WDATA;
  ring_master u_ring (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .rif     (rif),
    .req_q   (ring_req_d),
    .wr_q    (ring_wr_d),
    .adr_q   (ring_adr_d),
    .wd_q    (ring_wd_d),
    .done    (RING_DONE),
    .rd      (RING_RDATA)
  );
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      RING_REQ   <= 1'b0;
      RING_WRITE <= 1'b0;
      RING_ADDR  <= 16'h0000;
      RING_WDATA <= 8'h00;
    end else begin
      RING_REQ   <= ring_req_d && !RING_DONE;
      RING_WRITE <= ring_wr_d;
      RING_ADDR  <= ring_adr_d;
      RING_WDATA <= ring_wd_d;
    end
  end

  // ==========================================================
  // Special register read path, registered.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      if (mem_sel) begin
        SFR_RDATA <= mem_rdata;
      end else begin
        case (SFR_ADDR)
          SFR_SLEEP_CTRL:     SFR_RDATA <= ctrl_q;
          SFR_WDOG_FRAMES:    SFR_RDATA <= wdog_n_q;
          SFR_WAKE_LINE:      SFR_RDATA <= wake_line_q[15:8];
          SFR_WAKE_LINE + 16'h1:  SFR_RDATA <= wake_line_q[7:0];
          SFR_WAKE_SEL:       SFR_RDATA <= {wake_lvl_q, 4'h0, wake_sel_q};
          SFR_RESTART:        SFR_RDATA <= {6'h00, restart_q};
          SFR_RESTART + 16'h1:    SFR_RDATA <= start_q;
          SFR_TIMER:          SFR_RDATA <= timer_q[31:24];
          SFR_TIMER + 16'h1:      SFR_RDATA <= timer_q[23:16];
          SFR_TIMER + 16'h2:      SFR_RDATA <= timer_q[15:8];
          SFR_TIMER + 16'h3:      SFR_RDATA <= timer_q[7:0];
          SFR_TABLE_BASE:     SFR_RDATA <= base_q[15:8];
          SFR_TABLE_BASE + 16'h1: SFR_RDATA <= base_q[7:0];
          SFR_RD_PAGE:        SFR_RDATA <= rpage_q;
          SFR_RD_ADDR:        SFR_RDATA <= raddr_q;
          SFR_WR_PAGE:        SFR_RDATA <= wpage_q;
          SFR_WR_ADDR:        SFR_RDATA <= waddr_q;
          SFR_RING_DATA:      SFR_RDATA <= rif.rdata;
          SFR_RING_BUSY:      SFR_RDATA <= {7'h00, rif.busy};
          default:            SFR_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/mcu_support_checker.sv ====
// Port-level checks for the microcontroller support block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mcu_support_checker
  import mcu_sup_pkg::*;
(
  input wire logic        SYS_CLK,
  input wire logic        NRST,
  input wire logic        SFR_RD,
  input wire logic        SFR_WR,
  input wire logic [15:0] SFR_ADDR,
  input wire logic [7:0]  SFR_WDATA,
  input wire logic        HOST_START_WR,
  input wire logic [7:0]  HOST_START_CODE,
  input wire logic [7:0]  STARTUP_CODE,
  input wire logic        MCU_CLK_EN,
  input wire logic        MCU_RST_N,
  input wire logic        RING_REQ,
  input wire logic        RING_WRITE,
  input wire logic [15:0] RING_ADDR,
  input wire logic [7:0]  RING_WDATA,
  input wire logic        RING_DONE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  // ==========================================================
  // Ring window, sleep, watchdog and startup code.
  property p_req_cause; $rose(RING_REQ) |-> $past(SFR_WR &&
    (SFR_ADDR == SFR_RD_ADDR || SFR_ADDR == SFR_RING_DATA), 2); endproperty
  a_req_cause: assert property (p_req_cause)
    else $error("Ring request without a start.");
  property p_req_rdaddr; $rose(RING_REQ) && !RING_WRITE |->
    RING_ADDR[7:0] == $past(SFR_WDATA, 2); endproperty
  a_req_rdaddr: assert property (p_req_rdaddr)
    else $error("Ring read address wrong.");
  property p_req_wdata; $rose(RING_REQ) && RING_WRITE |->
    RING_WDATA == $past(SFR_WDATA, 2); endproperty
  a_req_wdata: assert property (p_req_wdata)
    else $error("Ring write data wrong.");
  property p_req_hold; RING_REQ && !RING_DONE |=> RING_REQ; endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("Ring request dropped early.");
  property p_req_drop; RING_REQ && RING_DONE |=> !RING_REQ; endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("Ring request held after done.");
  property p_sleep_cause; $fell(MCU_CLK_EN) |->
    $past(SFR_RD && SFR_ADDR == SFR_SLEEP_CTRL); endproperty
  a_sleep_cause: assert property (p_sleep_cause)
    else $error("Sleep without a control read.");
  property p_rst_pulse; !MCU_RST_N |=> MCU_RST_N; endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("Watchdog reset longer than one cycle.");
  property p_start_code; HOST_START_WR |->
    ##2 STARTUP_CODE == $past(HOST_START_CODE, 2); endproperty
  a_start_code: assert property (p_start_code)
    else $error("Startup code not stored.");
  c_ring_rd: cover property ($rose(RING_REQ) && !RING_WRITE);
  c_ring_wr: cover property ($rose(RING_REQ) && RING_WRITE);
  c_sleep: cover property ($fell(MCU_CLK_EN));
  c_wdog: cover property (!MCU_RST_N);
endmodule
bind mcu_support mcu_support_checker u_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .SFR_RD(SFR_RD), .SFR_WR(SFR_WR),
  .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
  .HOST_START_WR(HOST_START_WR), .HOST_START_CODE(HOST_START_CODE),
  .STARTUP_CODE(STARTUP_CODE), .MCU_CLK_EN(MCU_CLK_EN),
  .MCU_RST_N(MCU_RST_N), .RING_REQ(RING_REQ), .RING_WRITE(RING_WRITE),
  .RING_ADDR(RING_ADDR), .RING_WDATA(RING_WDATA), .RING_DONE(RING_DONE)
);
`default_nettype wire

// ==== tb/ring_slave_model.sv ====
// Behavioural ring bus slave: stores writes, answers after a lag.
// Assumes it shares the master clock with the block.
`timescale 1ns/1ps
`default_nettype none
module ring_slave_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [3:0]  lag,
  output logic             done,
  output logic [7:0]       rdata
);
  logic [7:0] mem [logic [15:0]];
  logic [7:0] rd_q = 8'h00;
  logic [3:0] cnt_q = 4'h0;
  logic       busy_q = 1'b0;
  // Outside the answer cycle the data lines carry a scrambled value.
  assign rdata = done ? rd_q : ~rd_q;
  initial done = 1'b0;
  always @(posedge clk) begin
    done <= 1'b0;
    if (req && !busy_q && !done) begin
      busy_q <= 1'b1;
      cnt_q  <= lag;
    end else if (busy_q && cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'b0;
      done   <= 1'b1;
      rd_q   <= mem.exists(addr) ? mem[addr] : 8'h00;
      if (wr) begin
        mem[addr] = wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/test_mcu_support.sv ====
// Self-checking bench for the microcontroller support block.
// Assumes the ring slave model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %0t %s", $time, msg); \
    end \
  end
module test_mcu_support
  import mcu_sup_pkg::*;
;
  logic        clk, nrst, stby, srd, swr, hrd, hwr, hlg, hsw, pl, pn;
  logic        cen, mrn, rq, rw, rdn;
  logic [15:0] sa, ha, ln, ra;
  logic [7:0]  swd, srq, hwd, hrq, hsc, sco, rwd, rrd, q;
  logic [3:0]  fe, lag;
  logic [31:0] ta, tb;
  int          fails = 0;
  int          n_checks = 0;
  int          n_rst = 0;
  mcu_support u_mcu_support (
    .SYS_CLK(clk), .NRST(nrst), .STANDBY(stby), .SFR_RD(srd),
    .SFR_WR(swr), .SFR_ADDR(sa), .SFR_WDATA(swd), .SFR_RDATA(srq),
    .HOST_RD(hrd), .HOST_WR(hwr), .HOST_LOGICAL(hlg), .HOST_VAR_ADDR(ha),
    .HOST_VAR_WDATA(hwd), .HOST_VAR_RDATA(hrq), .HOST_START_WR(hsw),
    .HOST_START_CODE(hsc), .STARTUP_CODE(sco), .PIPE_LINE(pl),
    .PIPE_LINE_NUM(ln), .PIPE_FRAME(fe[0]), .SENS_FRAME(fe[1]),
    .JPEG_FRAME(fe[2]), .FIFO_FRAME(fe[3]), .PORT_NOTIFY(pn),
    .MCU_CLK_EN(cen), .MCU_RST_N(mrn), .RING_REQ(rq), .RING_WRITE(rw),
    .RING_ADDR(ra), .RING_WDATA(rwd), .RING_DONE(rdn), .RING_RDATA(rrd)
  );
  ring_slave_model u_ring_slave_model (
    .clk(clk), .req(rq), .wr(rw), .addr(ra), .wdata(rwd), .lag(lag),
    .done(rdn), .rdata(rrd)
  );
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (nrst && !mrn) begin
      n_rst++;
    end
  end
  // ==========================================================
  // Bus tasks.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic sfr_wr(input logic [15:0] a, input logic [7:0] d);
    swr = 1'b1;
    sa = a;
    swd = d;
    tick(1);
    swr = 1'b0;
    tick(1);
  endtask
  task automatic sfr_rd(input logic [15:0] a);
    srd = 1'b1;
    sa = a;
    tick(1);
    srd = 1'b0;
    q = srq;
    tick(1);
  endtask
  task automatic rd32(output logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      sfr_rd(SFR_TIMER + 16'(i));
      v = {v[23:0], q};
    end
  endtask
  task automatic host(input logic w, l, input logic [15:0] a,
                      input logic [7:0] d);
    hrd = !w;
    hwr = w;
    hlg = l;
    ha = a;
    hwd = d;
    tick(1);
    hrd = 1'b0;
    hwr = 1'b0;
    tick(6);
    q = hrq;
  endtask
  task automatic poll();
    sfr_rd(SFR_RING_BUSY);
    `CHK(q, 8'h01, "busy not set")
    for (int i = 0; i < 40 && q !== 8'h00; i++) begin
      sfr_rd(SFR_RING_BUSY);
    end
    `CHK(q, 8'h00, "busy stuck")
    if (q !== 8'h00) begin
      tally_and_finish();
    end
  endtask
  task automatic wait_en();
    for (int i = 0; i < 40 && cen !== 1'b1; i++) begin
      tick(1);
    end
    `CHK(cen, 1'b1, "no wake")
    if (cen !== 1'b1) begin
      tally_and_finish();
    end
  endtask
  task automatic frame();
    fe[0] = 1'b1;
    tick(3);
    fe[0] = 1'b0;
    tick(3);
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_reset();
    `CHK(srq, 8'h00, "rdata")
    `CHK(cen, 1'b1, "asleep")
    `CHK(mrn, 1'b1, "mcu reset")
    `CHK(rq, 1'b0, "ring req")
    `CHK(sco, 8'h00, "startup")
    sfr_rd(SFR_RESTART);
    `CHK(q, {6'h00, RESTART_COLD}, "cold code")
    sfr_rd(SFR_WDOG_FRAMES);
    `CHK(q, WDOG_RESET_VAL, "wdog count")
    hsw = 1'b1;
    hsc = 8'h5a;
    tick(1);
    hsw = 1'b0;
    tick(1);
    `CHK(sco, 8'h5a, "startup code")
  endtask
  task automatic t_sram();
    sfr_wr(16'h0400, 8'h3c);
    host(1'b0, 1'b0, 16'h0400, 8'h00);
    `CHK(q, 8'h3c, "phys read")
    host(1'b1, 1'b0, 16'h07ff, 8'hc3);
    sfr_rd(16'h07ff);
    `CHK(q, 8'hc3, "phys write")
    sfr_wr(SFR_TABLE_BASE, 8'h01);
    sfr_wr(SFR_TABLE_BASE + 16'h1, 8'h00);
    sfr_wr(16'h0104, 8'h20);
    sfr_wr(16'h0105, 8'h02);
    sfr_wr(16'h0223, 8'h5a);
    host(1'b0, 1'b1, 16'h0203, 8'h00);
    `CHK(q, 8'h5a, "logical read")
    host(1'b1, 1'b1, 16'h0204, 8'h77);
    sfr_rd(16'h0224);
    `CHK(q, 8'h77, "logical write")
  endtask
  task automatic t_ring();
    sfr_wr(SFR_WR_PAGE, 8'h12);
    sfr_wr(SFR_WR_ADDR, 8'h34);
    sfr_wr(SFR_RING_DATA, 8'ha5);
    poll();
    lag = 4'h6;
    sfr_wr(SFR_RD_PAGE, 8'h12);
    sfr_wr(SFR_RD_ADDR, 8'h34);
    sfr_wr(SFR_RD_ADDR, 8'h99);
    poll();
    sfr_rd(SFR_RING_DATA);
    `CHK(q, 8'ha5, "ring data")
  endtask
  task automatic t_sleep();
    sfr_wr(SFR_WAKE_LINE, 8'h00);
    sfr_wr(SFR_WAKE_LINE + 16'h1, 8'h05);
    sfr_rd(SFR_WAKE_LINE + 16'h1);
    `CHK(q, 8'h05, "wake line")
    for (int s = 0; s < 5; s++) begin
      sfr_wr(SFR_WAKE_SEL, 8'(s) | ((s > 2) ? 8'h80 : 8'h00));
      sfr_wr(SFR_SLEEP_CTRL, 8'h00);
      sfr_rd(SFR_SLEEP_CTRL);
      `CHK(q[0], 1'b0, "event kept")
      `CHK(cen, 1'b0, "no sleep")
      pl = (s == 0);
      ln = (s == 0) ? 16'h0005 : 16'h0000;
      fe = (s == 0) ? 4'h0 : 4'(1 << (s - 1));
      tick(3);
      {pl, fe} = '0;
      wait_en();
      pn = 1'b1;
      ln = 16'h0000;
      tick(4);
      sfr_rd(SFR_SLEEP_CTRL);
      `CHK(q[0], 1'b1, "slept flag")
      `CHK(cen, 1'b1, "slept anyway")
      pn = 1'b0;
    end
  endtask
  task automatic t_wdog();
    sfr_wr(SFR_WDOG_FRAMES, 8'h02);
    sfr_wr(SFR_SLEEP_CTRL, 8'h00);
    frame();
    sfr_wr(SFR_SLEEP_CTRL, 8'h00);
    frame();
    `CHK(n_rst, 0, "early fire")
    frame();
    tick(4);
    `CHK(n_rst, 1, "no fire")
    sfr_rd(SFR_RESTART);
    `CHK(q, {6'h00, RESTART_WDOG}, "warm code")
    sfr_wr(SFR_WDOG_FRAMES, 8'h00);
    repeat (3) frame();
    `CHK(n_rst, 1, "fired while off")
  endtask
  task automatic t_timer();
    stby = 1'b1;
    tick(2);
    rd32(ta);
    tick(12);
    rd32(tb);
    `CHK(tb, ta, "ran in standby")
    stby = 1'b0;
    tick(2);
    rd32(ta);
    tick(12);
    rd32(tb);
    `CHK(tb - ta, 32'd20, "count step")
  endtask
  initial begin
    {clk, nrst, stby, srd, swr, hrd, hwr, hlg, hsw, pl, pn} = '0;
    {sa, ha, ln, swd, hwd, hsc, fe, lag} = '0;
    tick(4);
    nrst = 1'b1;
    t_reset();
    t_sram();
    t_ring();
    t_sleep();
    t_timer();
    t_wdog();
    tally_and_finish();
  end
endmodule
`default_nettype wire
